// >>> hwsu_store_unit.sv
// Guarded halfword/word store unit with APB status and control
`timescale 1ns/1ps
`default_nettype none
module hwsu_store_unit #(
  parameter logic [31:0] MMIO_BASE = hwsu_pkg::MMIO_BASE_DEF,
  parameter logic [31:0] MMIO_SIZE = hwsu_pkg::MMIO_SIZE_DEF
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  // Store issue
  input  wire logic        store_valid_in,
  input  wire logic [1:0]  store_kind_in,
  input  wire logic [31:0] base_operand_in,
  input  wire logic [8:0]  disp_in,
  input  wire logic [31:0] store_operand_in,
  input  wire logic        guard_present_in,
  input  wire logic        guard_bit_in,
  input  wire logic        interruptible_jump_in,
  // Memory and data cache
  output logic             mem_wr_out,
  output logic [31:0]      mem_addr_out,
  output logic [3:0]       mem_be_out,
  output logic [31:0]      mem_wdata_out,
  output logic             mem_mmio_out,
  output logic             cache_touch_out,
  // Status toward the core
  output logic             misaligned_store_flag_out,
  output logic             exception_req_out,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [2:0] {
    HWSU_TR_IDLE  = 3'h1,
    HWSU_TR_ARMED = 3'h2,
    HWSU_TR_REQ   = 3'h4
  } hwsu_trap_e;

  hwsu_trap_e  trap_reg;
  hwsu_trap_e  trap_next;

  logic        byte_order_bit_reg;
  logic        trap_enable_reg;
  logic        misal_flag_reg;
  logic [31:0] misaddr_reg;
  logic [31:0] stcnt_reg;
  logic [31:0] supcnt_reg;

  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        map_hit;

  logic        mem_wr_reg;
  logic [31:0] mem_addr_reg;
  logic [3:0]  mem_be_reg;
  logic [31:0] mem_wdata_reg;
  logic        mem_mmio_reg;
  logic        exc_req_reg;
  logic        touch_reg;

  logic        take;
  logic        enabled;
  logic        set_flag;
  logic        apb_acc;
  logic        apb_wr;

  hwsu_req_if req ();

  // ****************************************************************
  // Address generation and byte placement
  // ****************************************************************
  assign req.base       = base_operand_in;
  assign req.disp       = disp_in;
  assign req.kind       = hwsu_pkg::hwsu_kind_e'(store_kind_in);
  assign req.data       = store_operand_in;
  assign req.big_endian = byte_order_bit_reg;

  hwsu_agen #(
    .MMIO_BASE (MMIO_BASE),
    .MMIO_SIZE (MMIO_SIZE)
  ) u_agen (
    .req (req.agen)
  );

  hwsu_lanes u_lanes (
    .req (req.lanes)
  );

  // ****************************************************************
  // Guard and side effects
  // ****************************************************************
  // Absent guard always acts; given guard acts on its lsb
  assign enabled  = !guard_present_in || guard_bit_in;
  assign take     = store_valid_in && enabled;
  assign set_flag = take && req.misaligned;

  // Memory request: misaligned stores and halfwords into the
  // aperture are dropped, since their results are undefined anyway
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mem_wr_reg <= 1'b0;
      mem_mmio_reg <= 1'b0;
    end else begin
      mem_wr_reg <= take && !req.misaligned &&
                    !(req.in_mmio &&
                      req.kind == hwsu_pkg::HWSU_HALF_DISP);
      mem_mmio_reg <= take && req.in_mmio;
    end
  end

  // Cache status moves only for a written, cacheable store
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      touch_reg <= 1'b0;
    end else begin
      touch_reg <= take && !req.misaligned && !req.in_mmio;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mem_addr_reg  <= hwsu_pkg::RST_WORD;
      mem_be_reg    <= 4'h0;
      mem_wdata_reg <= hwsu_pkg::RST_WORD;
    end else if (take) begin
      mem_addr_reg  <= {req.eff_addr[31:2], 2'h0};
      mem_be_reg    <= req.be;
      mem_wdata_reg <= req.wdata;
    end
  end

  // ****************************************************************
  // Status word: byte order, trap enable, sticky flag
  // ****************************************************************
  assign apb_acc = psel_in && penable_in && pready_reg;
  assign apb_wr  = apb_acc && pwrite_in &&
                   paddr_in == hwsu_pkg::OFF_STATUS;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      byte_order_bit_reg <= hwsu_pkg::RST_BYTE_ORDER;
      trap_enable_reg    <= hwsu_pkg::RST_TRAP_EN;
    end else if (apb_wr) begin
      byte_order_bit_reg <= pwdata_in[hwsu_pkg::BIT_BYTE_ORDER];
      trap_enable_reg    <= pwdata_in[hwsu_pkg::BIT_TRAP_EN];
    end
  end

  // Write one clears; a new misaligned store wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      misal_flag_reg <= hwsu_pkg::RST_MISAL_FLAG;
    end else if (set_flag) begin
      misal_flag_reg <= 1'b1;
    end else if (apb_wr && pwdata_in[hwsu_pkg::BIT_MISAL_FLAG]) begin
      misal_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      misaddr_reg <= hwsu_pkg::RST_WORD;
    end else if (set_flag) begin
      misaddr_reg <= req.eff_addr;
    end
  end

  // ****************************************************************
  // Store counters
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      stcnt_reg  <= hwsu_pkg::RST_WORD;
      supcnt_reg <= hwsu_pkg::RST_WORD;
    end else begin
      if (take) begin
        stcnt_reg <= stcnt_reg + 32'h0000_0001;
      end
      if (store_valid_in && !enabled) begin
        supcnt_reg <= supcnt_reg + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Deferred misaligned-store trap
  // ****************************************************************
  always_comb begin
    trap_next = trap_reg;
    unique case (trap_reg)
      HWSU_TR_IDLE: begin
        if (set_flag && trap_enable_reg) begin
          trap_next = HWSU_TR_ARMED;
        end
      end
      HWSU_TR_ARMED: begin
        if (interruptible_jump_in) begin
          trap_next = HWSU_TR_REQ;
        end
      end
      HWSU_TR_REQ: begin
        if (set_flag && trap_enable_reg) begin
          trap_next = HWSU_TR_ARMED;
        end else begin
          trap_next = HWSU_TR_IDLE;
        end
      end
      default: begin
        trap_next = HWSU_TR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      trap_reg <= HWSU_TR_IDLE;
    end else begin
      trap_reg <= trap_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      exc_req_reg <= 1'b0;
    end else begin
      exc_req_reg <= (trap_reg == HWSU_TR_ARMED) &&
                     interruptible_jump_in;
    end
  end

  // ****************************************************************
  // APB slave: one wait state, error on unmapped address
  // ****************************************************************
  always_comb begin
    map_hit     = 1'b1;
    prdata_next = 32'h0000_0000;
    unique case (paddr_in)
      hwsu_pkg::OFF_STATUS: begin
        prdata_next[hwsu_pkg::BIT_BYTE_ORDER] = byte_order_bit_reg;
        prdata_next[hwsu_pkg::BIT_TRAP_EN]    = trap_enable_reg;
        prdata_next[hwsu_pkg::BIT_MISAL_FLAG] = misal_flag_reg;
        prdata_next[hwsu_pkg::BIT_TRAP_PEND]  =
          (trap_reg == HWSU_TR_ARMED);
      end
      hwsu_pkg::OFF_MISADDR: begin
        prdata_next = misaddr_reg;
      end
      hwsu_pkg::OFF_STCNT: begin
        prdata_next = stcnt_reg;
      end
      hwsu_pkg::OFF_SUPCNT: begin
        prdata_next = supcnt_reg;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= hwsu_pkg::RST_WORD;
    end else begin
      pready_reg  <= psel_in && penable_in && !pready_reg;
      pslverr_reg <= psel_in && penable_in && !pready_reg && !map_hit;
      if (psel_in && penable_in && !pready_reg && !pwrite_in) begin
        prdata_reg <= prdata_next;
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign mem_wr_out                = mem_wr_reg;
  assign mem_addr_out              = mem_addr_reg;
  assign mem_be_out                = mem_be_reg;
  assign mem_wdata_out             = mem_wdata_reg;
  assign mem_mmio_out              = mem_mmio_reg;
  assign cache_touch_out           = touch_reg;
  assign misaligned_store_flag_out = misal_flag_reg;
  assign exception_req_out         = exc_req_reg;
  assign prdata_out                = prdata_reg;
  assign pready_out                = pready_reg;
  assign pslverr_out               = pslverr_reg;

endmodule
`default_nettype wire

// >>> hwsu_pkg.sv
// Constants, types and register layout for the halfword/word store unit
package hwsu_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int DISP_W = 9;
  localparam int LANES  = 4;

  // ****************************************************************
  // Store kinds
  // ****************************************************************
  typedef enum logic [1:0] {
    HWSU_HALF_DISP = 2'h0,
    HWSU_WORD      = 2'h1,
    HWSU_WORD_DISP = 2'h2
  } hwsu_kind_e;

  // ****************************************************************
  // Byte placement constants
  // ****************************************************************
  localparam logic [1:0] HALF_SWAP = 2'h1;
  localparam logic [1:0] WORD_SWAP = 2'h3;

  // ****************************************************************
  // APB register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_MISADDR = 8'h04;
  localparam logic [7:0] OFF_STCNT   = 8'h08;
  localparam logic [7:0] OFF_SUPCNT  = 8'h0C;

  // Status word fields
  localparam int BIT_BYTE_ORDER = 0;
  localparam int BIT_TRAP_EN    = 1;
  localparam int BIT_MISAL_FLAG = 2;
  localparam int BIT_TRAP_PEND  = 3;

  // Reset values
  localparam logic        RST_BYTE_ORDER = 1'h0;
  localparam logic        RST_TRAP_EN    = 1'h0;
  localparam logic        RST_MISAL_FLAG = 1'h0;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  // I/O aperture defaults
  localparam logic [31:0] MMIO_BASE_DEF = 32'hF000_0000;
  localparam logic [31:0] MMIO_SIZE_DEF = 32'h0020_0000;

endpackage

// >>> hwsu_req_if.sv
// Carrier between store unit core, address generator and lane placer
`timescale 1ns/1ps
`default_nettype none
interface hwsu_req_if;
  logic [31:0]         base;
  logic [8:0]          disp;
  hwsu_pkg::hwsu_kind_e kind;
  logic [31:0]         data;
  logic                big_endian;
  logic [31:0]         eff_addr;
  logic                misaligned;
  logic                in_mmio;
  logic [3:0]          be;
  logic [31:0]         wdata;

  modport core  (output base, disp, kind, data, big_endian,
                 input  eff_addr, misaligned, in_mmio, be, wdata);
  modport agen  (input  base, disp, kind,
                 output eff_addr, misaligned, in_mmio);
  modport lanes (input  eff_addr, kind, data, big_endian, in_mmio,
                 output be, wdata);
endinterface
`default_nettype wire

// >>> hwsu_agen.sv
// Effective address, alignment check and aperture hit for a store
`timescale 1ns/1ps
`default_nettype none
module hwsu_agen #(
  parameter logic [31:0] MMIO_BASE = hwsu_pkg::MMIO_BASE_DEF,
  parameter logic [31:0] MMIO_SIZE = hwsu_pkg::MMIO_SIZE_DEF
) (
  hwsu_req_if.agen req
);
  logic [31:0] disp_ext;
  logic [31:0] mmio_off;

  // Plain word store forces a zero displacement
  always_comb begin
    if (req.kind == hwsu_pkg::HWSU_WORD) begin
      disp_ext = 32'h0000_0000;
    end else begin
      disp_ext = {{23{req.disp[8]}}, req.disp};
    end
  end

  // Wraps modulo 2^32
  assign req.eff_addr = req.base + disp_ext;
  assign mmio_off     = req.eff_addr - MMIO_BASE;
  assign req.in_mmio  = (mmio_off < MMIO_SIZE);

  always_comb begin
    if (req.kind == hwsu_pkg::HWSU_HALF_DISP) begin
      req.misaligned = req.eff_addr[0];
    end else begin
      req.misaligned = (req.eff_addr[1:0] != 2'h0);
    end
  end
endmodule
`default_nettype wire

// >>> hwsu_lanes.sv
// Byte lane enables and write data placement for a store
`timescale 1ns/1ps
`default_nettype none
module hwsu_lanes (
  hwsu_req_if.lanes req
);
  logic [1:0] swap;
  logic [1:0] off;

  always_comb begin
    req.be    = 4'h0;
    req.wdata = 32'h0000_0000;
    swap      = 2'h0;
    off       = 2'h0;
    if (req.kind == hwsu_pkg::HWSU_HALF_DISP) begin
      // Byte k of the halfword (k=0 high) lands at offset k ^ swap
      swap = req.big_endian ? 2'h0 : hwsu_pkg::HALF_SWAP;
      off  = {req.eff_addr[1], 1'b0};
      req.be[off] = 1'b1;
      req.be[off | 2'h1] = 1'b1;
      req.wdata[8*(off | (2'h0 ^ swap)) +: 8] = req.data[15:8];
      req.wdata[8*(off | (2'h1 ^ swap)) +: 8] = req.data[7:0];
    end else if (req.in_mmio) begin
      // Register sees the operand unchanged whatever the byte order
      req.be    = 4'hF;
      req.wdata = req.data;
    end else begin
      swap    = req.big_endian ? 2'h0 : hwsu_pkg::WORD_SWAP;
      req.be  = 4'hF;
      for (int k = 0; k < 4; k++) begin
        req.wdata[8*(2'(k) ^ swap) +: 8] = req.data[8*(3-k) +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// >>> hwsu_mem_model.sv
// Byte memory standing behind the store unit
`timescale 1ns/1ps
`default_nettype none
module hwsu_mem_model (
  // Write port from the store unit
  input wire logic        clk_in,
  input wire logic        wr_in,
  input wire logic [31:0] addr_in,
  input wire logic [3:0]  be_in,
  input wire logic [31:0] wdata_in
);
  logic [7:0] mem [logic [31:0]];

  // Accepts a write every cycle, no back-pressure
  always @(posedge clk_in) begin
    if (wr_in === 1'b1) begin
      for (int i = 0; i < 4; i++) begin
        if (be_in[i]) begin
          mem[addr_in + i] = wdata_in[8*i +: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> hwsu_store_unit_chk.sv
// Port checker for the store unit
`timescale 1ns/1ps
`default_nettype none
module hwsu_store_unit_chk #(
  parameter logic [31:0] MMIO_BASE = hwsu_pkg::MMIO_BASE_DEF,
  parameter logic [31:0] MMIO_SIZE = hwsu_pkg::MMIO_SIZE_DEF
) (
  // Clock, reset and store issue
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        store_valid_in,
  input wire logic [1:0]  store_kind_in,
  input wire logic [31:0] base_operand_in,
  input wire logic [8:0]  disp_in,
  input wire logic [31:0] store_operand_in,
  input wire logic        guard_present_in,
  input wire logic        guard_bit_in,
  input wire logic        interruptible_jump_in,
  // Outputs watched
  input wire logic        mem_wr_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [3:0]  mem_be_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic        mem_mmio_out,
  input wire logic        cache_touch_out,
  input wire logic        misaligned_store_flag_out,
  input wire logic        exception_req_out,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        pready_out
);
  logic [31:0] eff;
  logic [31:0] eff_q;
  logic [31:0] disp_x;
  logic        take;
  logic        word;
  logic        misal;
  logic        mmio;
  logic        apw;
  logic        gfalse;

  assign word   = store_kind_in != 2'h0;
  assign disp_x = (store_kind_in == 2'h1) ? 32'h0000_0000
                                          : {{23{disp_in[8]}}, disp_in};
  assign eff    = base_operand_in + disp_x;
  assign take   = store_valid_in && (!guard_present_in || guard_bit_in);
  assign gfalse = store_valid_in && guard_present_in && !guard_bit_in;
  assign misal  = word ? (eff[1:0] != 2'h0) : eff[0];
  assign mmio   = eff >= MMIO_BASE && (eff - MMIO_BASE) < MMIO_SIZE;
  assign apw    = psel_in && penable_in && pwrite_in && pready_out;

  always_ff @(posedge sys_clk_in) begin
    eff_q <= eff;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_guard_no_write: assert property (
    gfalse |=> !mem_wr_out && !cache_touch_out)
    else $error("guard false store wrote");
  a_guard_no_flag: assert property (
    gfalse && !apw |=> $stable(misaligned_store_flag_out))
    else $error("guard false store moved the flag");
  a_half_misal: assert property (
    take && !word && eff[0] |=> misaligned_store_flag_out)
    else $error("odd halfword store left flag clear");
  a_word_misal: assert property (
    take && word && eff[1:0] != 2'h0 |=> misaligned_store_flag_out)
    else $error("misaligned word store left flag clear");
  a_misal_no_wr: assert property (
    take && misal |=> !mem_wr_out)
    else $error("misaligned store wrote");
  a_word_place: assert property (
    take && word && !misal |=>
      mem_wr_out && mem_addr_out == eff_q && mem_be_out == 4'hF)
    else $error("word store address or lanes wrong");
  a_half_place: assert property (
    take && !word && !misal && !mmio |=> mem_wr_out &&
      mem_addr_out == {eff_q[31:2], 2'h0} &&
      mem_be_out == (eff_q[1] ? 4'hC : 4'h3))
    else $error("halfword store address or lanes wrong");
  a_half_mmio: assert property (
    take && !word && mmio |=> !mem_wr_out)
    else $error("halfword store into aperture wrote");
  a_mmio_raw: assert property (
    take && word && !misal && mmio |=>
      mem_mmio_out && mem_wdata_out == $past(store_operand_in))
    else $error("aperture word store data reordered");
  a_trap_cause: assert property (
    exception_req_out |-> $past(interruptible_jump_in))
    else $error("trap request without a jump");
  a_trap_pulse: assert property (
    exception_req_out |=> !exception_req_out)
    else $error("trap request held too long");
  a_flag_sticky: assert property (
    misaligned_store_flag_out && !apw |=> misaligned_store_flag_out)
    else $error("flag dropped by itself");
  a_touch_pair: assert property (
    cache_touch_out == (mem_wr_out && !mem_mmio_out))
    else $error("cache touch out of step with write");
endmodule

bind hwsu_store_unit hwsu_store_unit_chk #(
  .MMIO_BASE(MMIO_BASE), .MMIO_SIZE(MMIO_SIZE)
) chk_u (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .store_valid_in(store_valid_in), .store_kind_in(store_kind_in),
  .base_operand_in(base_operand_in), .disp_in(disp_in),
  .store_operand_in(store_operand_in),
  .guard_present_in(guard_present_in), .guard_bit_in(guard_bit_in),
  .interruptible_jump_in(interruptible_jump_in),
  .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
  .mem_be_out(mem_be_out), .mem_wdata_out(mem_wdata_out),
  .mem_mmio_out(mem_mmio_out), .cache_touch_out(cache_touch_out),
  .misaligned_store_flag_out(misaligned_store_flag_out),
  .exception_req_out(exception_req_out),
  .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .pready_out(pready_out)
);
`default_nettype wire

// >>> hwsu_store_unit_bench.sv
// Self-checking bench for the store unit
`timescale 1ns/1ps
`default_nettype none
module hwsu_store_unit_bench;
  localparam logic [31:0] MB = hwsu_pkg::MMIO_BASE_DEF;
  localparam logic [31:0] MS = hwsu_pkg::MMIO_SIZE_DEF;
  logic        clk = 0, srst = 1, st_vld = 0, g_pres = 0, g_bit = 0;
  logic        jmp = 0, psel = 0, pen = 0, pwr = 0, big = 0;
  logic [1:0]  st_kind = 0;
  logic [8:0]  st_disp = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] st_base = 0, st_op = 0, pwdata = 0, r;
  logic        wr, mmio, touch, flag, exc, pready, pslverr;
  logic [3:0]  be;
  logic [31:0] addr, wdata, prdata;
  logic [67:0] e;
  logic [67:0] expq [$];
  int          err_count = 0, checks = 0, sup = 0, tk = 0, seed = 52924;
  logic [31:0] ba [6] = '{32'hD00, 32'hD01, 32'hD02, 32'hD03, 32'hD04, 32'hD07};
  logic [7:0]  bv [6] = '{8'h44, 8'h33, 8'hCC, 8'hDD, 8'hAA, 8'hDD};

  always #2.5 clk = ~clk;

  hwsu_store_unit #(.MMIO_BASE(MB), .MMIO_SIZE(MS)) dut_u (
    .sys_clk_in(clk), .srst_in(srst), .store_valid_in(st_vld),
    .store_kind_in(st_kind), .base_operand_in(st_base), .disp_in(st_disp),
    .store_operand_in(st_op), .guard_present_in(g_pres), .guard_bit_in(g_bit),
    .interruptible_jump_in(jmp), .mem_wr_out(wr), .mem_addr_out(addr),
    .mem_be_out(be), .mem_wdata_out(wdata), .mem_mmio_out(mmio),
    .cache_touch_out(touch), .misaligned_store_flag_out(flag),
    .exception_req_out(exc), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  hwsu_mem_model mem_u (.clk_in(clk), .wr_in(wr), .addr_in(addr),
    .be_in(be), .wdata_in(wdata));

  // ********************************
  // Helpers
  // ********************************
  task automatic final_report;
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  function automatic logic [31:0] msk(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  function automatic logic in_mmio(input logic [31:0] a);
    return a >= MB && (a - MB) < MS;
  endfunction

  function automatic logic [67:0] place(input logic [1:0] k,
      input logic [31:0] a, input logic [31:0] op, input logic bg);
    logic [3:0]  m;
    logic [31:0] w;
    m = 4'hF;
    w = op;
    if (k == 2'h0) begin
      m = a[1] ? 4'hC : 4'h3;
      w = bg ? {2{op[7:0], op[15:8]}} : {2{op[15:0]}};
    end else if (bg && !in_mmio(a)) begin
      w = {op[7:0], op[15:8], op[23:16], op[31:24]};
    end
    return {a[31:2], 2'h0, m, w};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 32'h2);
    q = pslverr ? 32'hDEAD_0000 | prdata : prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic st(input logic [1:0] k, input logic [31:0] b,
                    input logic [8:0] d, input logic [31:0] op,
                    input logic [1:0] g);
    logic [31:0] a;
    logic        bad;
    a = b + ((k == 2'h1) ? 32'h0 : {{23{d[8]}}, d});
    bad = (k == 2'h0) ? a[0] : (a[1:0] != 2'h0);
    st_vld <= 1'b1;
    st_kind <= k;
    st_base <= b;
    st_disp <= d;
    st_op <= op;
    g_pres <= g[1];
    g_bit <= g[0];
    if (g == 2'h2) begin
      sup++;
    end else begin
      tk++;
      if (!bad && !(k == 2'h0 && in_mmio(a))) begin
        expq.push_back(place(k, a, op, big));
      end
    end
    @(posedge clk);
  endtask

  task automatic idle;
    st_vld <= 1'b0;
    @(posedge clk);
  endtask

  // Scoreboard on the memory side
  always @(posedge clk) begin
    if (wr === 1'b1) begin
      if (expq.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        chk(addr, e[67:36]);
        chk({28'h0, be}, {28'h0, e[35:32]});
        chk(wdata & msk(be), e[31:0] & msk(e[35:32]));
        chk({31'h0, touch}, {31'h0, !in_mmio(e[67:36])});
        chk({31'h0, mmio}, {31'h0, in_mmio(e[67:36])});
      end
    end
  end

  initial begin
    #100000;
    err_count++;
    final_report();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, hwsu_pkg::OFF_STATUS, 32'h0, r);
    chk(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'hDEAD_0000);
    big = 1'b1;
    apb(1'b1, hwsu_pkg::OFF_STATUS, 32'h1, r);
    st(2'h0, 32'hCFE, 9'h002, 32'h4433_2211, 2'h0);
    st(2'h2, 32'hCFC, 9'h004, 32'h4433_2211, 2'h3);
    st(2'h0, 32'hD05, 9'h1FC, 32'hAABB_CCDD, 2'h2);
    st(2'h0, 32'hD06, 9'h1FC, 32'hAABB_CCDD, 2'h3);
    st(2'h2, 32'hD0C, 9'h1F8, 32'hAABB_CCDD, 2'h3);
    st(2'h2, 32'h4, 9'h1F8, 32'h1234_5678, 2'h0);
    st(2'h0, MB, 9'h0, 32'h1, 2'h0);
    idle;
    foreach (ba[i]) begin
      chk({24'h0, mem_u.mem[ba[i]]}, {24'h0, bv[i]});
    end
    for (int p = 0; p < 2; p++) begin
      big = p[0];
      apb(1'b1, hwsu_pkg::OFF_STATUS, {31'h0, big}, r);
      for (int i = 0; i < 40; i++) begin
        r = $random(seed);
        st(r[1:0] % 3, r[13] ? (MB | (r & 32'h001F_FFFC))
           : $random(seed) & 32'hFFFF_FFFC,
           r[1] == r[0] ? {r[23], r[23:17], 1'b0} : {r[24:18], 2'h0},
           $random(seed), r[31:30]);
      end
      idle;
      apb(1'b0, hwsu_pkg::OFF_STATUS, 32'h0, r);
      chk(r, {31'h0, big});
    end
    big = 1'b0;
    apb(1'b1, hwsu_pkg::OFF_STATUS, 32'h2, r);
    st(2'h0, 32'hD01, 9'h0, 32'h55, 2'h3);
    idle;
    apb(1'b0, hwsu_pkg::OFF_STATUS, 32'h0, r);
    chk(r, 32'hE);
    apb(1'b0, hwsu_pkg::OFF_MISADDR, 32'h0, r);
    chk(r, 32'hD01);
    chk({31'h0, exc}, 32'h0);
    jmp <= 1'b1;
    @(posedge clk);
    jmp <= 1'b0;
    @(posedge clk);
    chk({31'h0, exc}, 32'h1);
    @(posedge clk);
    chk({31'h0, exc}, 32'h0);
    apb(1'b1, hwsu_pkg::OFF_STATUS, 32'h6, r);
    apb(1'b0, hwsu_pkg::OFF_STATUS, 32'h0, r);
    chk(r, 32'h2);
    st(2'h2, 32'hD02, 9'h004, 32'h66, 2'h0);
    idle;
    apb(1'b0, hwsu_pkg::OFF_MISADDR, 32'h0, r);
    chk(r, 32'hD06);
    apb(1'b1, hwsu_pkg::OFF_SUPCNT, 32'hFFFF, r);
    apb(1'b0, hwsu_pkg::OFF_SUPCNT, 32'h0, r);
    chk(r, sup);
    apb(1'b0, hwsu_pkg::OFF_STCNT, 32'h0, r);
    chk(r, tk);
    chk(expq.size(), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
